// ===== bstp_defines.svh
/*
  Constants of the boundary-scan test port: instruction codes, register
  lengths, scan chain layout, reset values and identity code.
  Assumes inclusion by bare name from the package and the design modules.
*/
// Function
// - Test reset low puts the port controller into reset at once.
// - Serial input bits are captured on rising test clock edges in the shift states only.
// - Serial output takes its next bit on every falling test clock edge.
// - State select sampled on rising edge steers the standard state walk.
// - Serial output can be released to high impedance.
// - In test mode digital pins are scan cells; output clocks have none.
`ifndef BSTP_DEFINES_SVH
`define BSTP_DEFINES_SVH

`define BSTP_IR_LEN 3
`define BSTP_IR_CAPTURE 3'h1
`define BSTP_IR_EXTEST 3'h0
`define BSTP_IR_SAMPLE 3'h2
`define BSTP_IR_IDCODE 3'h1
`define BSTP_IR_BYPASS 3'h7
`define BSTP_ID_LEN 32
// Identity value arbitrary, low bit set as the standard demands
`define BSTP_ID_VALUE 32'h0BAD_1001
`define BSTP_NUM_PINS 8
`define BSTP_CHAIN_LEN 16
`define BSTP_CELL_DATA 0
`define BSTP_CELL_ENA 1

`endif

// ===== bstp_pkg.sv
/*
  Types of the boundary-scan test port: controller states.
  Assumes bstp_defines.svh is on the include path.
*/
`include "bstp_defines.svh"
package bstp_pkg;
  typedef enum logic [3:0] {
    TestLogicReset,
    RunIdle,
    SelectDr,
    CaptureDr,
    ShiftDr,
    Exit1Dr,
    PauseDr,
    Exit2Dr,
    UpdateDr,
    SelectIr,
    CaptureIr,
    ShiftIr,
    Exit1Ir,
    PauseIr,
    Exit2Ir,
    UpdateIr
  } bstp_state_t;
endpackage

// ===== bstp_tap_fsm.sv
/*
  Test port controller state machine on the test clock.
  Assumes state select comes from the tester on the same test clock.
*/
`timescale 1ns/10ps
module bstp_tap_fsm (
  input wire logic testPortClock,
  input wire logic testPortResetN,
  input wire logic testStateSelect,
  output bstp_pkg::bstp_state_t state
);
  import bstp_pkg::*;

  bstp_state_t state_reg;
  bstp_state_t state_next;

  assign state = state_reg;

  // Standard walk; all-ones path from any state ends in reset
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      TestLogicReset: state_next = testStateSelect ? TestLogicReset : RunIdle;
      RunIdle: state_next = testStateSelect ? SelectDr : RunIdle;
      SelectDr: state_next = testStateSelect ? SelectIr : CaptureDr;
      CaptureDr: state_next = testStateSelect ? Exit1Dr : ShiftDr;
      ShiftDr: state_next = testStateSelect ? Exit1Dr : ShiftDr;
      Exit1Dr: state_next = testStateSelect ? UpdateDr : PauseDr;
      PauseDr: state_next = testStateSelect ? Exit2Dr : PauseDr;
      Exit2Dr: state_next = testStateSelect ? UpdateDr : ShiftDr;
      UpdateDr: state_next = testStateSelect ? SelectDr : RunIdle;
      SelectIr: state_next = testStateSelect ? TestLogicReset : CaptureIr;
      CaptureIr: state_next = testStateSelect ? Exit1Ir : ShiftIr;
      ShiftIr: state_next = testStateSelect ? Exit1Ir : ShiftIr;
      Exit1Ir: state_next = testStateSelect ? UpdateIr : PauseIr;
      PauseIr: state_next = testStateSelect ? Exit2Ir : PauseIr;
      Exit2Ir: state_next = testStateSelect ? UpdateIr : ShiftIr;
      UpdateIr: state_next = testStateSelect ? SelectDr : RunIdle;
      default: state_next = TestLogicReset;
    endcase
  end

  always_ff @(posedge testPortClock or negedge testPortResetN)
  begin
    if (!testPortResetN)
      state_reg <= TestLogicReset;
    else
      state_reg <= state_next;
  end
endmodule // bstp_tap_fsm

// ===== bstp_tester.sv
/*
  Boundary-scan tester model: makes the test clock only within frames.
  Assumes the device samples on rising and drives on falling edges.
*/
`timescale 1ns/10ps
module bstp_tester (
  output logic testPortClock,
  output logic testStateSelect,
  output logic testSerialIn,
  input wire logic testSerialOut,
  input wire logic testSerialOutOe
);
  logic lastSeen;
  initial
  begin
    testPortClock = 1'h0;
    testStateSelect = 1'h1;
    testSerialIn = 1'h0;
    lastSeen = 1'h0;
  end
  // Released line reads as the inverse of the last bit
  task automatic tick(input logic m, input logic d, output logic o);
    testStateSelect = m;
    testSerialIn = d;
    #15;
    o = (testSerialOutOe === 1'h1) ? testSerialOut : ~lastSeen;
    lastSeen = o;
    testPortClock = 1'h1;
    #15;
    testPortClock = 1'h0;
  endtask
  task automatic walk(input int n, input logic [31:0] m);
    logic o;
    for (int i = 0; i < n; i++)
      tick(m[i], 1'h0, o);
  endtask
  task automatic shift(input int n, input logic [31:0] din,
    output logic [31:0] dout);
    logic o;
    dout = '0;
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    walk(4, 32'h1);
  endtask
  task automatic resetTap();
    walk(6, 32'h1F);
  endtask
  task automatic scanIr(input logic [2:0] c, output logic [31:0] dout);
    walk(4, 32'h3);
    shift(3, {29'h0, c}, dout);
  endtask
  task automatic scanDr(input int n, input logic [31:0] din,
    output logic [31:0] dout);
    walk(3, 32'h1);
    shift(n, din, dout);
  endtask
endmodule // bstp_tester

// ===== bstp_top.sv
/*
  Boundary-scan test port: controller, instruction register, bypass,
  identity and boundary registers, pad multiplexing in the system domain.
  Assumes the test clock is unrelated to clk; output clock pins are
  routed outside this block and never pass through it.
*/
`timescale 1ns/10ps
`include "bstp_defines.svh"
module bstp_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic testPortClock,
  input wire logic testPortResetN,
  input wire logic testStateSelect,
  input wire logic testSerialIn,
  output logic testSerialOut,
  output logic testSerialOutOe,
  input wire logic [`BSTP_NUM_PINS-1:0] padIn,
  output logic [`BSTP_NUM_PINS-1:0] padOut,
  output logic [`BSTP_NUM_PINS-1:0] padOe,
  input wire logic [`BSTP_NUM_PINS-1:0] coreOut,
  input wire logic [`BSTP_NUM_PINS-1:0] coreOe,
  output logic [`BSTP_NUM_PINS-1:0] coreIn,
  output logic testMode
);
  import bstp_pkg::*;

  localparam int NP = `BSTP_NUM_PINS;
  localparam int CL = `BSTP_CHAIN_LEN;
  localparam int IL = `BSTP_IR_LEN;
  localparam int DL = `BSTP_ID_LEN;

  bstp_state_t tapState;

  // Test clock domain
  logic [IL-1:0] irShift_reg;
  logic [IL-1:0] irShift_next;
  logic [IL-1:0] ir_reg;
  logic bypass_reg;
  logic [DL-1:0] idShift_reg;
  logic [DL-1:0] idShift_next;
  logic [CL-1:0] bsShift_reg;
  logic [CL-1:0] bsShift_next;
  logic [CL-1:0] bsUpd_reg;
  logic updToggle_reg;
  logic extest_reg;
  logic [NP-1:0] capPinA_reg;
  logic [NP-1:0] capPinB_reg;
  logic [NP-1:0] capOeA_reg;
  logic [NP-1:0] capOeB_reg;
  logic tdo_reg;
  logic tdoOe_reg;

  // System clock domain
  logic [NP-1:0] padInA_reg;
  logic [NP-1:0] padInB_reg;
  logic [NP-1:0] coreOeQ_reg;
  logic modeA_reg;
  logic modeB_reg;
  logic [2:0] togSync_reg;
  logic [CL-1:0] updCopy_reg;
  logic [NP-1:0] padOut_reg;
  logic [NP-1:0] padOe_reg;
  logic [NP-1:0] coreIn_reg;

  bstp_tap_fsm tapFsm (
    .testPortClock(testPortClock),
    .testPortResetN(testPortResetN),
    .testStateSelect(testStateSelect),
    .state(tapState)
  );

  // State decodes
  wire inReset = (tapState == TestLogicReset);
  wire capIr = (tapState == CaptureIr);
  wire shIr = (tapState == ShiftIr);
  wire updIr = (tapState == UpdateIr);
  wire capDr = (tapState == CaptureDr);
  wire shDr = (tapState == ShiftDr);
  wire updDr = (tapState == UpdateDr);

  // Instruction decodes; unknown codes fall back to bypass
  wire selId = (ir_reg == `BSTP_IR_IDCODE);
  wire selBs = (ir_reg == `BSTP_IR_EXTEST) || (ir_reg == `BSTP_IR_SAMPLE);
  wire selExt = (ir_reg == `BSTP_IR_EXTEST);
  wire selByp = !selId && !selBs;

  // Boundary cell capture values, two cells per digital pin
  logic [CL-1:0] bsCapture;
  logic [NP-1:0] updData;
  logic [NP-1:0] updEna;
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++)
    begin : gCell
      assign bsCapture[2*gi+`BSTP_CELL_DATA] = capPinB_reg[gi];
      assign bsCapture[2*gi+`BSTP_CELL_ENA] = capOeB_reg[gi];
      assign updData[gi] = updCopy_reg[2*gi+`BSTP_CELL_DATA];
      assign updEna[gi] = updCopy_reg[2*gi+`BSTP_CELL_ENA];
    end
  endgenerate

  assign irShift_next = capIr ? `BSTP_IR_CAPTURE
                      : {testSerialIn, irShift_reg[IL-1:1]};
  assign idShift_next = capDr ? `BSTP_ID_VALUE
                      : {testSerialIn, idShift_reg[DL-1:1]};
  assign bsShift_next = capDr ? bsCapture
                      : {testSerialIn, bsShift_reg[CL-1:1]};

  wire drBit = selId ? idShift_reg[0]
             : selBs ? bsShift_reg[0]
             : bypass_reg;
  wire tdoNext = shIr ? irShift_reg[0] : drBit;
  wire tdoOeNext = shIr || shDr;

  always_ff @(posedge testPortClock or negedge testPortResetN)
  begin
    if (!testPortResetN)
      irShift_reg <= `BSTP_IR_CAPTURE;
    else if (capIr || shIr)
      irShift_reg <= irShift_next;
  end

  always_ff @(posedge testPortClock or negedge testPortResetN)
  begin
    if (!testPortResetN)
      ir_reg <= `BSTP_IR_IDCODE;
    else if (inReset)
      ir_reg <= `BSTP_IR_IDCODE;
    else if (updIr)
      ir_reg <= irShift_reg;
  end

  always_ff @(posedge testPortClock or negedge testPortResetN)
  begin
    if (!testPortResetN)
      bypass_reg <= 1'h0;
    else if (selByp && (capDr || shDr))
      bypass_reg <= capDr ? 1'h0 : testSerialIn;
  end

  always_ff @(posedge testPortClock or negedge testPortResetN)
  begin
    if (!testPortResetN)
      idShift_reg <= `BSTP_ID_VALUE;
    else if (selId && (capDr || shDr))
      idShift_reg <= idShift_next;
  end

  always_ff @(posedge testPortClock or negedge testPortResetN)
  begin
    if (!testPortResetN)
      bsShift_reg <= '0;
    else if (selBs && (capDr || shDr))
      bsShift_reg <= bsShift_next;
  end

  // Update stage; toggle tells the system domain a new word stands
  always_ff @(posedge testPortClock or negedge testPortResetN)
  begin
    if (!testPortResetN)
    begin
      bsUpd_reg <= '0;
      updToggle_reg <= 1'h0;
    end
    else if (selBs && updDr)
    begin
      bsUpd_reg <= bsShift_reg;
      updToggle_reg <= !updToggle_reg;
    end
  end

  always_ff @(posedge testPortClock or negedge testPortResetN)
  begin
    if (!testPortResetN)
      extest_reg <= 1'h0;
    else
      extest_reg <= selExt && !inReset;
  end

  // Pin levels from the system domain into the test clock domain
  always_ff @(posedge testPortClock or negedge testPortResetN)
  begin
    if (!testPortResetN)
    begin
      capPinA_reg <= '0;
      capPinB_reg <= '0;
      capOeA_reg <= '0;
      capOeB_reg <= '0;
    end
    else
    begin
      capPinA_reg <= padInB_reg;
      capPinB_reg <= capPinA_reg;
      capOeA_reg <= coreOeQ_reg;
      capOeB_reg <= capOeA_reg;
    end
  end

  // Output stage on the falling edge, released outside shift states
  always_ff @(negedge testPortClock or negedge testPortResetN)
  begin
    if (!testPortResetN)
    begin
      tdo_reg <= 1'h0;
      tdoOe_reg <= 1'h0;
    end
    else
    begin
      tdo_reg <= tdoNext;
      tdoOe_reg <= tdoOeNext;
    end
  end

  // System domain: pad synchronisers and crossing of test mode/update
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      padInA_reg <= '0;
      padInB_reg <= '0;
      coreOeQ_reg <= '0;
      modeA_reg <= 1'h0;
      modeB_reg <= 1'h0;
      togSync_reg <= '0;
    end
    else
    begin
      padInA_reg <= padIn;
      padInB_reg <= padInA_reg;
      coreOeQ_reg <= coreOe;
      modeA_reg <= extest_reg;
      modeB_reg <= modeA_reg;
      togSync_reg <= {togSync_reg[1:0], updToggle_reg};
    end
  end

  wire updSeen = togSync_reg[2] ^ togSync_reg[1];

  // Update word stays still for many test clocks after the toggle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      updCopy_reg <= '0;
    else if (updSeen)
      updCopy_reg <= bsUpd_reg;
  end

  wire [NP-1:0] padOutNext = modeB_reg ? updData : coreOut;
  wire [NP-1:0] padOeNext = modeB_reg ? updEna : coreOe;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      padOut_reg <= '0;
      padOe_reg <= '0;
      coreIn_reg <= '0;
    end
    else
    begin
      padOut_reg <= padOutNext;
      padOe_reg <= padOeNext;
      coreIn_reg <= padInB_reg;
    end
  end

  assign testSerialOut = tdo_reg;
  assign testSerialOutOe = tdoOe_reg;
  assign padOut = padOut_reg;
  assign padOe = padOe_reg;
  assign coreIn = coreIn_reg;
  assign testMode = modeB_reg;
endmodule // bstp_top

// ===== bstp_top_asserts.sv
/*
  Checker of the boundary-scan test port, bound to bstp_top.
  Assumes the test clock idles low between frames.
*/
`timescale 1ns/10ps
`include "bstp_defines.svh"
module bstp_top_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic testPortClock,
  input wire logic testPortResetN,
  input wire logic testStateSelect,
  input wire logic testSerialOut,
  input wire logic testSerialOutOe,
  input wire logic [`BSTP_NUM_PINS-1:0] padIn,
  input wire logic [`BSTP_NUM_PINS-1:0] padOut,
  input wire logic [`BSTP_NUM_PINS-1:0] padOe,
  input wire logic [`BSTP_NUM_PINS-1:0] coreOut,
  input wire logic [`BSTP_NUM_PINS-1:0] coreOe,
  input wire logic [`BSTP_NUM_PINS-1:0] coreIn,
  input wire logic testMode
);
  logic riseOut_reg;
  logic riseOe_reg;
  // Output levels seen at the last rising test clock edge
  always_ff @(posedge testPortClock or negedge testPortResetN)
  begin
    if (!testPortResetN)
    begin
      riseOut_reg <= 1'h0;
      riseOe_reg <= 1'h0;
    end
    else
    begin
      riseOut_reg <= testSerialOut;
      riseOe_reg <= testSerialOutOe;
    end
  end
  oe_reset_a: assert property (
    @(posedge clk)
    !testPortResetN && !$past(testPortResetN) |-> !testSerialOutOe)
    else $error("serial output enabled in test reset");
  tdo_fall_a: assert property (
    @(negedge testPortClock) disable iff (!testPortResetN)
    testSerialOut == riseOut_reg)
    else $error("serial output moved on rising edge");
  oe_fall_a: assert property (
    @(negedge testPortClock) disable iff (!testPortResetN)
    testSerialOutOe == riseOe_reg)
    else $error("output enable moved on rising edge");
  reset_walk_a: assert property (
    @(posedge testPortClock) disable iff (!testPortResetN)
    testStateSelect[*5] |=> !testSerialOutOe)
    else $error("five high selects left output on");
  ir_capture_a: assert property (
    @(posedge testPortClock) disable iff (!testPortResetN)
    testStateSelect[*5] ##1 !testStateSelect ##1 testStateSelect[*2]
    ##1 (!testStateSelect)[*2] |=> testSerialOutOe && testSerialOut)
    else $error("instruction capture bit wrong");
  id_first_a: assert property (
    @(posedge testPortClock) disable iff (!testPortResetN)
    testStateSelect[*5] ##1 !testStateSelect ##1 testStateSelect
    ##1 (!testStateSelect)[*2] |=> testSerialOutOe && testSerialOut)
    else $error("identity first bit wrong");
  pads_follow_a: assert property (
    @(posedge clk) disable iff (rst)
    !$past(rst) && !$past(testMode, 2) && !$past(testMode) && !testMode
    |-> padOut == $past(coreOut) && padOe == $past(coreOe))
    else $error("pads do not follow core");
  core_in_a: assert property (
    @(posedge clk) disable iff (rst)
    !$past(rst, 4) |-> coreIn == $past(padIn, 3))
    else $error("core input lags wrongly");
  cover property (@(posedge clk) disable iff (rst) $rose(testMode));
  cover property (@(posedge clk) disable iff (rst) $fell(testMode));
  cover property (@(posedge testPortClock) testSerialOutOe);
endmodule // bstp_top_asserts
bind bstp_top bstp_top_asserts bstp_top_asserts_inst (.clk, .rst,
  .testPortClock, .testPortResetN, .testStateSelect, .testSerialOut,
  .testSerialOutOe, .padIn, .padOut, .padOe, .coreOut, .coreOe, .coreIn,
  .testMode);

// ===== tb_top.sv
/*
  Testbench of the boundary-scan test port with its tester model.
  Assumes the design's defines header is on the include path.
*/
`timescale 1ns/10ps
`include "bstp_defines.svh"
module tb_top;
  logic clk, rst, testPortClock, testPortResetN, testStateSelect;
  logic testSerialIn, testSerialOut, testSerialOutOe, testMode;
  logic [7:0] padIn, padOut, padOe, coreOut, coreOe, coreIn;
  logic [31:0] dout, word;
  int badCount, checks, seed;
  bstp_top bstp_top_inst (.clk, .rst, .testPortClock, .testPortResetN,
    .testStateSelect, .testSerialIn, .testSerialOut, .testSerialOutOe,
    .padIn, .padOut, .padOe, .coreOut, .coreOe, .coreIn, .testMode);
  bstp_tester bstp_tester_inst (.testPortClock, .testStateSelect,
    .testSerialIn, .testSerialOut, .testSerialOutOe);
  function automatic logic [31:0] capWord(input logic [7:0] d,
    input logic [7:0] e);
    capWord = '0;
    for (int i = 0; i < 8; i++)
      capWord[2*i +: 2] = {e[i], d[i]};
  endfunction
  function automatic logic [7:0] pick(input logic [31:0] w, input int k);
    for (int i = 0; i < 8; i++)
      pick[i] = w[2*i+k];
  endfunction
  task automatic checkScan(input string n, input logic [31:0] e,
    input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      badCount++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic checkPins(input string n, input logic [7:0] e,
    input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      badCount++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic completeRun();
    if (badCount == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic newPads();
    @(posedge clk);
    #5;
    padIn = $random(seed);
    coreOut = $random(seed);
    coreOe = $random(seed);
    repeat (8) @(posedge clk);
  endtask
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    #300000;
    badCount++;
    completeRun();
  end
  initial
  begin
    seed = 55;
    badCount = 0;
    checks = 0;
    rst = 1'h1;
    testPortResetN = 1'h0;
    {padIn, coreOut, coreOe} = '0;
    repeat (2) @(posedge clk);
    #5;
    rst = 1'h0;
    testPortResetN = 1'h1;
    bstp_tester_inst.resetTap();
    bstp_tester_inst.scanDr(32, 32'h0, dout);
    checkScan("idcode", `BSTP_ID_VALUE, dout);
    for (int c = 3; c < 8; c++)
    begin
      bstp_tester_inst.resetTap();
      bstp_tester_inst.scanIr(c[2:0], dout);
      checkScan("ircap", 32'h1, dout);
      word = $random(seed);
      bstp_tester_inst.scanDr(8, word, dout);
      checkScan("bypass", {24'h0, word[6:0], 1'h0}, dout);
    end
    bstp_tester_inst.resetTap();
    bstp_tester_inst.scanDr(32, 32'h0, dout);
    checkScan("walkreset", `BSTP_ID_VALUE, dout);
    bstp_tester_inst.scanIr(3'h7, dout);
    bstp_tester_inst.walk(4, 32'h1);
    checkPins("oeon", 8'h1, {7'h0, testSerialOutOe});
    // Test reset held over two system clock edges, clock stopped
    @(posedge clk);
    #5;
    testPortResetN = 1'h0;
    repeat (2) @(posedge clk);
    #5;
    checkPins("oe", 8'h0, {7'h0, testSerialOutOe});
    testPortResetN = 1'h1;
    bstp_tester_inst.walk(1, 32'h0);
    bstp_tester_inst.scanDr(32, 32'h0, dout);
    checkScan("trst", `BSTP_ID_VALUE, dout);
    newPads();
    checkPins("padout", coreOut, padOut);
    checkPins("corein", padIn, coreIn);
    bstp_tester_inst.scanIr(3'h2, dout);
    for (int k = 0; k < 4; k++)
    begin
      if (k == 1)
        bstp_tester_inst.scanIr(3'h0, dout);
      word = $random(seed);
      bstp_tester_inst.scanDr(16, word, dout);
      checkScan("capture", capWord(padIn, coreOe), dout);
      repeat (10) @(posedge clk);
      checkPins("mode", {7'h0, k > 0}, {7'h0, testMode});
      checkPins("pdata", k > 0 ? pick(word, 0) : coreOut, padOut);
      checkPins("pena", k > 0 ? pick(word, 1) : coreOe, padOe);
      newPads();
    end
    bstp_tester_inst.scanIr(3'h1, dout);
    newPads();
    checkPins("release", coreOe, padOe);
    checkPins("relout", coreOut, padOut);
    completeRun();
  end
endmodule // tb_top
